// ===== verilog/umsfp_map.svh
`ifndef UMSFP_MAP_SVH
`define UMSFP_MAP_SVH

`define UMSFP_ADDR_W 32
`define UMSFP_DATA_W 32
`define UMSFP_NUM_UART 4

`define UMSFP_ADDR_CLK0 32'h4000_40d0
`define UMSFP_ADDR_CLK1 32'h4000_40d4
`define UMSFP_ADDR_CLK2 32'h4000_40d8
`define UMSFP_ADDR_CLK3 32'h4000_40dc
`define UMSFP_ADDR_MSR 32'h4008_0018
`define UMSFP_ADDR_MCR 32'h4008_0010
`define UMSFP_ADDR_LEV0 32'h4008_001c
`define UMSFP_ADDR_LEV1 32'h4008_801c
`define UMSFP_ADDR_LEV2 32'h4009_001c
`define UMSFP_ADDR_LEV3 32'h4009_801c
`define UMSFP_ADDR_IRQST 32'h4008_0040
`define UMSFP_ADDR_IRQMSK 32'h4008_0044

`define UMSFP_CLK_W 17
`define UMSFP_CLK_RST 17'h0_0000
`define UMSFP_MCR_W 5
`define UMSFP_MCR_RST 5'h00
`define UMSFP_MCR_LOOP 4
`define UMSFP_MCR_DTR 0
`define UMSFP_MCR_RTS 1
`define UMSFP_MCR_OUT1 2
`define UMSFP_MCR_OUT2 3
`define UMSFP_LEV_W 7
`define UMSFP_LEV_RST 7'h00
`define UMSFP_EVT_W 4
`define UMSFP_EVT_RST 4'h0
`define UMSFP_PIN_IDLE 4'hf
`define UMSFP_CTS 0
`define UMSFP_DSR 1
`define UMSFP_RI 2
`define UMSFP_DCD 3
`define UMSFP_ACC_RST 8'h00
`define UMSFP_ZERO8 8'h00
`define UMSFP_TICK_RST 4'h0
`define UMSFP_RD_RST 32'h0000_0000

`endif

// ===== verilog/umsfp_pkg.sv
`default_nettype none
package umsfp_pkg;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } umsfp_modem_t;

  typedef struct packed {
    logic srcBus;
    logic [7:0] numer;
    logic [7:0] denom;
  } umsfp_prediv_t;

  typedef struct packed {
    logic tick;
    logic [7:0] acc;
  } umsfp_step_t;

endpackage
`default_nettype wire

// ===== verilog/umsfp_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "umsfp_map.svh"

module umsfp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`UMSFP_ADDR_W-1:0] addr,
  input wire logic [`UMSFP_DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [`UMSFP_DATA_W-1:0] rdData,
  input wire umsfp_pkg::umsfp_modem_t modemPins,
  input wire logic [`UMSFP_NUM_UART-1:0][`UMSFP_LEV_W-1:0] rxLevelIn,
  input wire logic periphTick,
  input wire logic busTick,
  output logic [`UMSFP_NUM_UART-1:0] baudRefTick,
  output logic irq
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // one accumulator step of the fractional divider
  function automatic umsfp_pkg::umsfp_step_t divStep(
    input umsfp_pkg::umsfp_prediv_t cfg,
    input logic [7:0] acc,
    input logic tickIn
  );
    logic [8:0] sum;
    umsfp_pkg::umsfp_step_t res;
    sum = {1'b0, acc} + {1'b0, cfg.numer};
    res.tick = 1'b0;
    res.acc = acc;
    if ((cfg.numer == `UMSFP_ZERO8) || (cfg.denom == `UMSFP_ZERO8)) begin
      res.acc = `UMSFP_ACC_RST;
    end else if (tickIn) begin
      if (sum >= {1'b0, cfg.denom}) begin
        res.tick = 1'b1;
        res.acc = 8'(sum - {1'b0, cfg.denom});
      end else begin
        res.acc = sum[7:0];
      end
    end
    return res;
  endfunction

  // address of the clock select register of a given uart
  function automatic logic [`UMSFP_ADDR_W-1:0] clkAddr(input int idx);
    logic [`UMSFP_ADDR_W-1:0] a;
    case (idx)
      0: a = `UMSFP_ADDR_CLK0;
      1: a = `UMSFP_ADDR_CLK1;
      2: a = `UMSFP_ADDR_CLK2;
      default: a = `UMSFP_ADDR_CLK3;
    endcase
    return a;
  endfunction

  // address of the fill level register of a given uart
  function automatic logic [`UMSFP_ADDR_W-1:0] levAddr(input int idx);
    logic [`UMSFP_ADDR_W-1:0] a;
    case (idx)
      0: a = `UMSFP_ADDR_LEV0;
      1: a = `UMSFP_ADDR_LEV1;
      2: a = `UMSFP_ADDR_LEV2;
      default: a = `UMSFP_ADDR_LEV3;
    endcase
    return a;
  endfunction

  // ------------------------------------------------------------
  // modem input synchroniser
  // ------------------------------------------------------------
  umsfp_pkg::umsfp_modem_t syncA_reg;
  umsfp_pkg::umsfp_modem_t syncB_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle pins are high, so reset state matches and no false edge follows
      syncA_reg <= `UMSFP_PIN_IDLE;
      syncB_reg <= `UMSFP_PIN_IDLE;
    end else begin
      syncA_reg <= modemPins;
      syncB_reg <= syncA_reg;
    end
  end

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  logic msrRd;
  logic irqStRd;
  logic mcrWr;
  logic mskWr;

  always_comb begin
    msrRd = rdStb && (addr == `UMSFP_ADDR_MSR);
    irqStRd = rdStb && (addr == `UMSFP_ADDR_IRQST);
    mcrWr = wrStb && (addr == `UMSFP_ADDR_MCR);
    mskWr = wrStb && (addr == `UMSFP_ADDR_IRQMSK);
  end

  // ------------------------------------------------------------
  // modem control and status
  // ------------------------------------------------------------
  logic [`UMSFP_MCR_W-1:0] mcr_reg;
  logic [`UMSFP_MCR_W-1:0] mcr_next;
  logic [`UMSFP_EVT_W-1:0] state_reg;
  logic [`UMSFP_EVT_W-1:0] state_next;
  logic [`UMSFP_EVT_W-1:0] flags_reg;
  logic [`UMSFP_EVT_W-1:0] flags_next;
  logic primed_reg;
  logic primed_next;
  logic [`UMSFP_EVT_W-1:0] events;
  logic loopOn;

  always_comb begin
    loopOn = mcr_reg[`UMSFP_MCR_LOOP];
    mcr_next = mcr_reg;
    if (mcrWr) begin
      mcr_next = wrData[`UMSFP_MCR_W-1:0];
    end
    state_next[`UMSFP_CTS] = loopOn ? mcr_reg[`UMSFP_MCR_RTS] : ~syncB_reg.cts;
    state_next[`UMSFP_DSR] = loopOn ? mcr_reg[`UMSFP_MCR_DTR] : ~syncB_reg.dsr;
    state_next[`UMSFP_RI] = loopOn ? mcr_reg[`UMSFP_MCR_OUT1] : ~syncB_reg.ri;
    state_next[`UMSFP_DCD] = loopOn ? mcr_reg[`UMSFP_MCR_OUT2] : ~syncB_reg.dcd;
    primed_next = 1'b1;
    events = `UMSFP_EVT_RST;
    if (primed_reg) begin
      events[`UMSFP_CTS] = state_next[`UMSFP_CTS] ^ state_reg[`UMSFP_CTS];
      events[`UMSFP_DSR] = state_next[`UMSFP_DSR] ^ state_reg[`UMSFP_DSR];
      events[`UMSFP_RI] = state_reg[`UMSFP_RI] & ~state_next[`UMSFP_RI];
      events[`UMSFP_DCD] = state_next[`UMSFP_DCD] ^ state_reg[`UMSFP_DCD];
    end
    flags_next = (flags_reg & ~{`UMSFP_EVT_W{msrRd}}) | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_reg <= `UMSFP_MCR_RST;
      state_reg <= `UMSFP_EVT_RST;
      flags_reg <= `UMSFP_EVT_RST;
      primed_reg <= 1'b0;
    end else begin
      mcr_reg <= mcr_next;
      state_reg <= state_next;
      flags_reg <= flags_next;
      primed_reg <= primed_next;
    end
  end

  // modem state feeds status and interrupt logic only
  // no path from state_reg to baud or data logic

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  logic [`UMSFP_EVT_W-1:0] irqSt_reg;
  logic [`UMSFP_EVT_W-1:0] irqSt_next;
  logic [`UMSFP_EVT_W-1:0] irqMsk_reg;
  logic [`UMSFP_EVT_W-1:0] irqMsk_next;
  logic irq_next;

  always_comb begin
    irqSt_next = (irqSt_reg & ~{`UMSFP_EVT_W{irqStRd}}) | events;
    irqMsk_next = irqMsk_reg;
    if (mskWr) begin
      irqMsk_next = wrData[`UMSFP_EVT_W-1:0];
    end
    irq_next = |(irqSt_next & irqMsk_next);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqSt_reg <= `UMSFP_EVT_RST;
      irqMsk_reg <= `UMSFP_EVT_RST;
      irq <= 1'b0;
    end else begin
      irqSt_reg <= irqSt_next;
      irqMsk_reg <= irqMsk_next;
      irq <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // fill levels and clock pre-dividers
  // ------------------------------------------------------------
  logic [`UMSFP_NUM_UART-1:0][`UMSFP_LEV_W-1:0] lev_reg;
  umsfp_pkg::umsfp_prediv_t [`UMSFP_NUM_UART-1:0] cfg_reg;
  umsfp_pkg::umsfp_prediv_t [`UMSFP_NUM_UART-1:0] cfg_next;
  logic [`UMSFP_NUM_UART-1:0][7:0] acc_reg;
  logic [`UMSFP_NUM_UART-1:0][7:0] acc_next;
  logic [`UMSFP_NUM_UART-1:0] tick_next;
  umsfp_pkg::umsfp_step_t step;
  logic srcTick;

  always_comb begin
    step = '0;
    srcTick = 1'b0;
    for (int i = 0; i < `UMSFP_NUM_UART; i++) begin
      cfg_next[i] = cfg_reg[i];
      if (wrStb && (addr == clkAddr(i))) begin
        cfg_next[i] = wrData[`UMSFP_CLK_W-1:0];
      end
      srcTick = cfg_reg[i].srcBus ? busTick : periphTick;
      step = divStep(cfg_reg[i], acc_reg[i], srcTick);
      acc_next[i] = step.acc;
      tick_next[i] = step.tick;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `UMSFP_NUM_UART; i++) begin
        cfg_reg[i] <= `UMSFP_CLK_RST;
        acc_reg[i] <= `UMSFP_ACC_RST;
        lev_reg[i] <= `UMSFP_LEV_RST;
      end
      baudRefTick <= `UMSFP_TICK_RST;
    end else begin
      cfg_reg <= cfg_next;
      acc_reg <= acc_next;
      lev_reg <= rxLevelIn;
      baudRefTick <= tick_next;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [`UMSFP_DATA_W-1:0] rdData_next;

  always_comb begin
    rdData_next = `UMSFP_RD_RST;
    if (rdStb) begin
      if (addr == `UMSFP_ADDR_MSR) begin
        rdData_next[7:0] = {state_reg, flags_reg};
      end
      if (addr == `UMSFP_ADDR_MCR) begin
        rdData_next[`UMSFP_MCR_W-1:0] = mcr_reg;
      end
      if (addr == `UMSFP_ADDR_IRQST) begin
        rdData_next[`UMSFP_EVT_W-1:0] = irqSt_reg;
      end
      if (addr == `UMSFP_ADDR_IRQMSK) begin
        rdData_next[`UMSFP_EVT_W-1:0] = irqMsk_reg;
      end
      for (int i = 0; i < `UMSFP_NUM_UART; i++) begin
        if (addr == clkAddr(i)) begin
          rdData_next[`UMSFP_CLK_W-1:0] = cfg_reg[i];
        end
        if (addr == levAddr(i)) begin
          rdData_next[`UMSFP_LEV_W-1:0] = lev_reg[i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= `UMSFP_RD_RST;
    end else begin
      rdData <= rdData_next;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_CTS_FLAG: assert property (
    primed_reg && (state_next[0] != state_reg[0]) |=> flags_reg[0] && irqSt_reg[0]
  ) else $error("cts change not flagged");

  AST_DSR_FLAG: assert property (
    primed_reg && (state_next[1] != state_reg[1]) |=> flags_reg[1]
  ) else $error("dsr change not flagged");

  AST_RING_CLR: assert property (
    msrRd && !(primed_reg && state_reg[2] && !state_next[2]) |=> !flags_reg[2]
  ) else $error("ring flag not cleared by read");

  AST_RING_FALL: assert property (
    primed_reg && !state_reg[2] && state_next[2] && !flags_reg[2] |=> !flags_reg[2]
  ) else $error("ring flag set on falling pin");

  AST_DCD_FLAG: assert property (
    primed_reg && (state_next[3] != state_reg[3]) |=> flags_reg[3]
  ) else $error("carrier change not flagged");

  AST_CTS_STATE: assert property (
    !loopOn |=> state_reg[0] == ~$past(syncB_reg.cts)
  ) else $error("cts state not inverse of pin");

  AST_CTS_LOOP: assert property (
    loopOn |=> state_reg[0] == $past(mcr_reg[1])
  ) else $error("cts state not from control bit1");

  AST_DSR_STATE: assert property (
    !loopOn |=> state_reg[1] == ~$past(syncB_reg.dsr)
  ) else $error("dsr state not inverse of pin");

  AST_RI_STATE: assert property (
    !loopOn |=> state_reg[2] == ~$past(syncB_reg.ri)
  ) else $error("ring state not inverse of pin");

  AST_DCD_STATE: assert property (
    !loopOn |=> state_reg[3] == ~$past(syncB_reg.dcd)
  ) else $error("carrier state not inverse of pin");

  AST_RING_RISE: assert property (
    primed_reg && state_reg[2] && !state_next[2] |=> flags_reg[2]
  ) else $error("ring rise not flagged");

  AST_DSR_LOOP: assert property (
    loopOn |=> state_reg[1] == $past(mcr_reg[0])
  ) else $error("dsr state not from control bit0");

  AST_RI_LOOP: assert property (
    loopOn |=> state_reg[2] == $past(mcr_reg[2])
  ) else $error("ring state not from control bit2");

  AST_DCD_LOOP: assert property (
    loopOn |=> state_reg[3] == $past(mcr_reg[3])
  ) else $error("carrier state not from control bit3");

  AST_MSR_READ: assert property (
    msrRd |=> rdData == {24'h00_0000, $past(state_reg), $past(flags_reg)}
  ) else $error("status readback wrong");

  AST_LEV_READ: assert property (
    rdStb && (addr == `UMSFP_ADDR_LEV0) |=> rdData == {25'h000_0000, $past(lev_reg[0])}
  ) else $error("fill level readback wrong");

  AST_BUS_SRC: assert property (
    cfg_reg[0].srcBus && !busTick |=> !baudRefTick[0]
  ) else $error("divider ticked without bus clock");

  AST_ZERO_STOP: assert property (
    (cfg_reg[1].numer == 8'h00) || (cfg_reg[1].denom == 8'h00) |=> !baudRefTick[1]
  ) else $error("stopped divider ticked");

  AST_RATIO_ONE: assert property (
    (cfg_reg[0].numer == cfg_reg[0].denom) && (cfg_reg[0].denom != 8'h00) &&
    !cfg_reg[0].srcBus && periphTick |=> baudRefTick[0]
  ) else $error("unity ratio missed a tick");

  AST_IRQ_LEVEL: assert property (
    irq == |(irqSt_reg & irqMsk_reg)
  ) else $error("interrupt level wrong");

  COV_RING: cover property (primed_reg && state_reg[2] && !state_next[2]);
  COV_LOOP: cover property (loopOn ##1 flags_reg[0]);
  COV_TICK: cover property (baudRefTick[2] ##[1:20] baudRefTick[2]);
  COV_IRQ: cover property (irq ##1 irqStRd ##1 !irq);

endmodule
`default_nettype wire

// ===== verification/umsfp_modem_line.sv
`timescale 1ns/1ps
`default_nettype none

// far-side modem: pins follow the wanted levels after lag cycles
module umsfp_modem_line (
  input wire logic clk,
  input wire umsfp_pkg::umsfp_modem_t want,
  input wire logic [2:0] lag,
  output umsfp_pkg::umsfp_modem_t modemPins
);
  umsfp_pkg::umsfp_modem_t hist [0:7];

  // ----------------------------------------
  // line delay
  // ----------------------------------------
  always_ff @(posedge clk) begin
    hist[0] <= want;
    for (int k = 1; k < 8; k++) begin
      hist[k] <= hist[k - 1];
    end
  end

  // lag 0 answers at once, larger lags model a slow line
  assign modemPins = (lag == 3'h0) ? want : hist[lag - 3'h1];
endmodule
`default_nettype wire

// ===== verification/tb_umsfp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "umsfp_map.svh"

module tb_umsfp_top;
  logic clk, rst, wrStb, rdStb, periphTick, busTick, irq;
  logic [31:0] addr, wrData, rdData;
  logic [3:0] want, baudRefTick;
  logic [2:0] lag;
  logic [3:0][6:0] rxLevelIn;
  umsfp_pkg::umsfp_modem_t modemPins;
  int fail_count, tests_run;
  logic [31:0] lvAddr [4] = '{`UMSFP_ADDR_LEV0, `UMSFP_ADDR_LEV1, `UMSFP_ADDR_LEV2, `UMSFP_ADDR_LEV3};
  logic [31:0] ckAddr [4] = '{`UMSFP_ADDR_CLK0, `UMSFP_ADDR_CLK1, `UMSFP_ADDR_CLK2, `UMSFP_ADDR_CLK3};

  umsfp_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .modemPins(modemPins), .rxLevelIn(rxLevelIn),
    .periphTick(periphTick), .busTick(busTick), .baudRefTick(baudRefTick), .irq(irq));
  umsfp_modem_line i_line (.clk(clk), .want(want), .lag(lag), .modemPins(modemPins));

  always #20 clk = ~clk;

  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(nm, exp, rdData);
    @(posedge clk);
  endtask
  function automatic logic [31:0] mExp(input logic [3:0] st, input logic [3:0] fl);
    return {24'h00_0000, st, fl};
  endfunction
  task automatic cntTicks(input int u, input int exp);
    int c;
    c = 0;
    idle(4);
    repeat (20) begin
      @(posedge clk);
      #1;
      if (baudRefTick[u] === 1'b1) c++;
    end
    chk("baud_ticks", 32'(exp), 32'(c));
    @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testReset();
    rdc("msr_rst", `UMSFP_ADDR_MSR, 32'h0000_0000); // zero at reset
    for (int k = 0; k < 4; k++) begin
      rdc("clk_rst", ckAddr[k], 32'h0000_0000); // reset value
      rdc("lev_rst", lvAddr[k], 32'h0000_0000); // reset value
    end
    $display("test reset done");
  endtask

  task automatic testModem();
    logic [3:0] fl;
    wr(`UMSFP_ADDR_IRQMSK, 32'h0000_000f);
    rdc("msk_rd", `UMSFP_ADDR_IRQMSK, 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      lag <= 3'(i);
      fl = 4'h0;
      if (i != 2) fl[i] = 1'b1;
      want[i] <= 1'b0;
      idle(12);
      chk("irq_fall", {31'h0000_0000, irq}, {31'h0000_0000, fl != 4'h0}); // edge seen, except ring pin fall
      rdc("msr_fall", `UMSFP_ADDR_MSR, mExp(~want, fl));
      rdc("msr_clr", `UMSFP_ADDR_MSR, mExp(~want, 4'h0)); // read clears
      rdc("irq_st", `UMSFP_ADDR_IRQST, {28'h000_0000, fl});
      want[i] <= 1'b1;
      fl = 4'h0;
      fl[i] = 1'b1;
      idle(12);
      chk("irq_rise", {31'h0000_0000, irq}, 32'h0000_0001);
      rdc("msr_rise", `UMSFP_ADDR_MSR, mExp(~want, fl)); // rise flag
      rdc("irq_st2", `UMSFP_ADDR_IRQST, {28'h000_0000, fl});
      chk("irq_off", {31'h0000_0000, irq}, 32'h0000_0000);
      rdc("msr_clr2", `UMSFP_ADDR_MSR, mExp(~want, 4'h0)); // read clears
    end
    wr(`UMSFP_ADDR_MSR, 32'h0000_00ff);
    rdc("msr_ro", `UMSFP_ADDR_MSR, 32'h0000_0000); // write ignored
    lag <= 3'h0;
    $display("test modem done");
  endtask

  task automatic testLoop();
    wr(`UMSFP_ADDR_MCR, 32'h0000_001f);
    idle(4);
    rdc("loop_all", `UMSFP_ADDR_MSR, 32'h0000_00fb); // loopback map
    wr(`UMSFP_ADDR_MCR, 32'h0000_0012);
    want <= 4'h0;
    idle(8);
    rdc("loop_rts", `UMSFP_ADDR_MSR, 32'h0000_001e); // pins ignored
    rdc("mcr_rd", `UMSFP_ADDR_MCR, 32'h0000_0012); // control readback
    want <= 4'hf;
    wr(`UMSFP_ADDR_MCR, 32'h0000_0000);
    idle(4);
    rdc("loop_exit", `UMSFP_ADDR_MSR, 32'h0000_0001); // back to pins
    rdc("loop_irq", `UMSFP_ADDR_IRQST, 32'h0000_000f);
    $display("test loopback done");
  endtask

  task automatic testPrediv();
    periphTick <= 1'b1;
    busTick <= 1'b0;
    wr(ckAddr[0], 32'h0000_0102); // reduced ratio
    cntTicks(0, 10); // half rate
    wr(ckAddr[0], 32'h0000_0304); // numerator below denominator
    cntTicks(0, 15); // three of four
    wr(ckAddr[0], 32'h0000_0004);
    cntTicks(0, 0); // zero numerator stops
    wr(ckAddr[0], 32'h0000_0100);
    cntTicks(0, 0); // zero denominator stops
    wr(ckAddr[0], 32'h0001_0102);
    cntTicks(0, 0); // bus clock idle
    busTick <= 1'b1;
    cntTicks(0, 10); // bus clock source
    wr(ckAddr[3], 32'h0000_0101);
    cntTicks(3, 20); // own divider
    cntTicks(2, 0); // divider 2 stays off
    wr(ckAddr[1], 32'hffff_ffff);
    rdc("clk_w", ckAddr[1], 32'h0001_ffff); // field widths
    $display("test prediv done");
  endtask

  task automatic testLevel();
    rxLevelIn <= {7'h40, 7'h15, 7'h00, 7'h7f};
    wr(lvAddr[0], 32'h0000_0011);
    idle(3);
    rdc("lev0", lvAddr[0], 32'h0000_007f); // full count
    rdc("lev1", lvAddr[1], 32'h0000_0000); // empty
    rdc("lev2", lvAddr[2], 32'h0000_0015); // fill level
    rdc("lev3", lvAddr[3], 32'h0000_0040); // fill level
    rdc("unmapped", 32'h4008_0030, 32'h0000_0000);
    $display("test level done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 32'h0000_0000;
    wrData = 32'h0000_0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    want = 4'hf;
    lag = 3'h0;
    rxLevelIn = '0;
    periphTick = 1'b0;
    busTick = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testModem();
    testLoop();
    testPrediv();
    testLevel();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
